/* logic/ppf_pkg.sv */
// shared constants of the programmable pin function block
// assumes a single 40 MHz core clock and synchronous pin inputs
package ppf_pkg;

  // core clock and smbus controller clock rate
  localparam int CLK_HZ     = 40_000_000;
  localparam int SMB_SCL_HZ = 1_000_000;
  localparam int SMB_DIV_W  = 8;
  // half period of the smbus clock, in core cycles, minus one
  localparam logic [SMB_DIV_W-1:0] SMB_HALF_LAST = SMB_DIV_W'(CLK_HZ / (2 * SMB_SCL_HZ) - 1);

  // counts of repeated functions, and the width of the debounce time
  localparam int SPI_HOSTS    = 2;
  localparam int SPI_SELECTS  = 7;
  localparam int REFCLK_PORTS = 2;
  localparam int DB_CHANNELS  = 4;
  localparam int DB_TIME_W    = 16;

  // debouncer channel indices
  localparam int DB_SPI0_ALERT  = 0;
  localparam int DB_SPI1_ALERT  = 1;
  localparam int DB_SMB_ALERT   = 2;
  localparam int DB_SERIAL_WAKE = 3;

  // reset and idle levels
  localparam logic [SPI_SELECTS-1:0] SEL_IDLE  = 7'h7f;
  localparam logic                   PIN_HIGH  = 1'h1;
  localparam logic                   PIN_LOW   = 1'h0;

endpackage

/* logic/ppf_db_if.sv */
// carrier between the pin block and one input debouncer
// assumes the debouncer runs on the same clock as the pin block
`timescale 1ns/1ps
interface ppf_db_if #(
  parameter int W = 16
);
  logic         raw;
  logic         enable;
  logic [W-1:0] limit;
  logic         filtered;

  modport core (output raw, output enable, output limit, input filtered);
  modport filt (input raw, input enable, input limit, output filtered);
endinterface

/* logic/ppf_debounce.sv */
// one input debouncer with restart on change
// assumes raw is synchronous to clk; limit is the debounce time in cycles
`timescale 1ns/1ps
module ppf_debounce #(
  parameter int   W        = 16,
  parameter logic RST_LEVEL = 1'h1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // pin side and function side
  ppf_db_if.filt   db
);

  logic         stable_q;
  logic         stable_d;
  logic         cand_q;
  logic         cand_d;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    stable_d = stable_q;
    cand_d   = cand_q;
    cnt_d    = cnt_q;
    if (!db.enable) begin
      stable_d = db.raw;
      cand_d   = db.raw;
      cnt_d    = '0;
    end else if (db.raw != cand_q) begin
      cand_d = db.raw;
      cnt_d  = '0;
    end else if (cand_q != stable_q) begin
      if (cnt_q >= db.limit) begin
        stable_d = cand_q;
        cnt_d    = '0;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stable_q <= RST_LEVEL;
      cand_q   <= RST_LEVEL;
      cnt_q    <= '0;
    end else if (ce) begin
      stable_q <= stable_d;
      cand_q   <= cand_d;
      cnt_q    <= cnt_d;
    end
  end

  // disabled debouncer passes the raw level straight through
  assign db.filtered = db.enable ? stable_q : db.raw;

endmodule

/* logic/ppf_pin_functions.sv */
// pin-level logic of the programmable pin functions
// assumes pins arrive synchronous to clk; open-drain pins use in/out/oe triples resolved outside, the smbus clock an out/oe pair only
`timescale 1ns/1ps
module ppf_pin_functions #(
  parameter int DB_W = ppf_pkg::DB_TIME_W
) (
  // clock, reset, clock enable
  input  wire logic                                      clk,
  input  wire logic                                      reset,
  input  wire logic                                      ce,
  // function selects
  input  wire logic                                      sel_link_wake,
  input  wire logic                                      obff_mode,
  input  wire logic                                      sel_aux_power,
  input  wire logic [ppf_pkg::REFCLK_PORTS-1:0]          sel_refclk_req,
  input  wire logic [ppf_pkg::SPI_HOSTS-1:0]             sel_spi_host,
  input  wire logic                                      sel_smbus_alert,
  input  wire logic                                      sel_smbus_clock,
  input  wire logic                                      sel_serial0_wake,
  // debouncer configuration
  input  wire logic [ppf_pkg::DB_CHANNELS-1:0]           db_enable,
  input  wire logic [ppf_pkg::DB_CHANNELS-1:0][DB_W-1:0] db_time,
  // link wake
  input  wire logic                                      wake_event,
  input  wire logic                                      link_wake_in_n,
  output      logic                                      link_wake_out_n,
  output      logic                                      link_wake_oe,
  output      logic                                      obff_event,
  output      logic                                      obff_active,
  // aux power detect
  input  wire logic                                      aux_power_detect,
  output      logic                                      aux_pulldown_en,
  output      logic                                      aux_pme_d3cold_ok,
  // reference clock requests
  input  wire logic [ppf_pkg::REFCLK_PORTS-1:0]          refclk_req_assert,
  input  wire logic                                      port0_refclk_request_n_in,
  output      logic                                      port0_refclk_request_n_out,
  output      logic                                      port0_refclk_request_n_oe,
  input  wire logic                                      port1_refclk_request_n_in,
  output      logic                                      port1_refclk_request_n_out,
  output      logic                                      port1_refclk_request_n_oe,
  output      logic [ppf_pkg::REFCLK_PORTS-1:0]          refclk_req_seen,
  // spi hosts
  input  wire logic [ppf_pkg::SPI_HOSTS-1:0][ppf_pkg::SPI_SELECTS-1:0] spi_select_req,
  input  wire logic [ppf_pkg::SPI_HOSTS-1:0]             spi_clock_req,
  output      logic [ppf_pkg::SPI_SELECTS-1:0]           spi_host0_select_n,
  output      logic [ppf_pkg::SPI_SELECTS-1:0]           spi_host1_select_n,
  output      logic                                      spi_host0_clock_out,
  output      logic                                      spi_host1_clock_out,
  input  wire logic                                      spi_host0_alert_in_n,
  input  wire logic                                      spi_host1_alert_in_n,
  output      logic [ppf_pkg::SPI_HOSTS-1:0]             spi_alert,
  // smbus controller
  input  wire logic                                      smbus_clock_run,
  output      logic                                      smbus_host_clock_out,
  output      logic                                      smbus_host_clock_oe,
  input  wire logic                                      smbus_host_alert_in_n,
  output      logic                                      smbus_alert,
  // serial wake
  input  wire logic                                      serial0_wake_req,
  input  wire logic                                      serial0_wake_in_n,
  output      logic                                      serial0_wake_out_n,
  output      logic                                      serial0_wake_oe,
  output      logic                                      serial0_wake_seen
);

  // debouncer channels
  logic [ppf_pkg::DB_CHANNELS-1:0] db_raw;
  logic [ppf_pkg::DB_CHANNELS-1:0] db_sel;
  logic [ppf_pkg::DB_CHANNELS-1:0] db_out;

  assign db_raw[ppf_pkg::DB_SPI0_ALERT]  = spi_host0_alert_in_n;
  assign db_raw[ppf_pkg::DB_SPI1_ALERT]  = spi_host1_alert_in_n;
  assign db_raw[ppf_pkg::DB_SMB_ALERT]   = smbus_host_alert_in_n;
  assign db_raw[ppf_pkg::DB_SERIAL_WAKE] = serial0_wake_in_n;
  assign db_sel[ppf_pkg::DB_SPI0_ALERT]  = sel_spi_host[0];
  assign db_sel[ppf_pkg::DB_SPI1_ALERT]  = sel_spi_host[1];
  assign db_sel[ppf_pkg::DB_SMB_ALERT]   = sel_smbus_alert;
  assign db_sel[ppf_pkg::DB_SERIAL_WAKE] = sel_serial0_wake;

  generate
    for (genvar c = 0; c < ppf_pkg::DB_CHANNELS; c++) begin : g_db
      ppf_db_if #(.W(DB_W)) dbi ();
      assign dbi.raw    = db_raw[c];
      assign dbi.enable = db_enable[c] & db_sel[c];
      assign dbi.limit  = db_time[c];
      assign db_out[c]  = dbi.filtered;
      ppf_debounce #(
        .W         (DB_W),
        .RST_LEVEL (ppf_pkg::PIN_HIGH)
      ) u_db (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .db    (dbi)
      );
    end
  endgenerate

  // registered pin-facing state
  logic                                   wake_oe_q, wake_oe_d;
  logic                                   wake_prev_q, wake_prev_d;
  logic                                   obff_event_q, obff_event_d;
  logic                                   obff_active_q, obff_active_d;
  logic                                   aux_ok_q, aux_ok_d;
  logic [ppf_pkg::REFCLK_PORTS-1:0]       rc_oe_q, rc_oe_d;
  logic [ppf_pkg::REFCLK_PORTS-1:0]       rc_seen_q, rc_seen_d;
  logic [ppf_pkg::REFCLK_PORTS-1:0]       rc_pin;
  logic [ppf_pkg::SPI_HOSTS-1:0][ppf_pkg::SPI_SELECTS-1:0] sel_n_q, sel_n_d;
  logic [ppf_pkg::SPI_HOSTS-1:0]          sclk_q, sclk_d;
  logic [ppf_pkg::SPI_HOSTS-1:0]          alert_q, alert_d;
  logic                                   smb_alert_q, smb_alert_d;
  logic                                   scl_high_q, scl_high_d;
  logic [ppf_pkg::SMB_DIV_W-1:0]          scl_cnt_q, scl_cnt_d;
  logic                                   ser_oe_q, ser_oe_d;
  logic                                   ser_seen_q, ser_seen_d;

  assign rc_pin = {port1_refclk_request_n_in, port0_refclk_request_n_in};

  always_comb begin
    // link wake: drive low on a wake event, input only in flush/fill mode
    wake_oe_d     = sel_link_wake & ~obff_mode & wake_event;
    wake_prev_d   = link_wake_in_n;
    obff_event_d  = sel_link_wake & obff_mode & wake_prev_q & ~link_wake_in_n;
    obff_active_d = sel_link_wake & obff_mode & ~link_wake_in_n;
    // aux detect: override to low when another function owns the pin
    aux_ok_d      = sel_aux_power & aux_power_detect;
    // reference clock requests: drive low only, sense while selected
    rc_oe_d       = sel_refclk_req & refclk_req_assert;
    rc_seen_d     = sel_refclk_req & ~rc_pin;
    // spi hosts: active-low selects, clock low while idle or unselected
    for (int h = 0; h < ppf_pkg::SPI_HOSTS; h++) begin
      sel_n_d[h] = sel_spi_host[h] ? ~spi_select_req[h] : ppf_pkg::SEL_IDLE;
      sclk_d[h]  = sel_spi_host[h] & spi_clock_req[h];
    end
    alert_d[0]  = sel_spi_host[0] & ~db_out[ppf_pkg::DB_SPI0_ALERT];
    alert_d[1]  = sel_spi_host[1] & ~db_out[ppf_pkg::DB_SPI1_ALERT];
    smb_alert_d = sel_smbus_alert & ~db_out[ppf_pkg::DB_SMB_ALERT];
    // smbus controller clock divider
    scl_high_d = ppf_pkg::PIN_HIGH;
    scl_cnt_d  = '0;
    if (sel_smbus_clock & smbus_clock_run) begin
      if (scl_cnt_q == ppf_pkg::SMB_HALF_LAST) begin
        scl_high_d = ~scl_high_q;
      end else begin
        scl_high_d = scl_high_q;
        scl_cnt_d  = scl_cnt_q + ppf_pkg::SMB_DIV_W'(1);
      end
    end
    // serial wake: open-drain low drive, debounced pin sense
    ser_oe_d   = sel_serial0_wake & serial0_wake_req;
    ser_seen_d = sel_serial0_wake & ~db_out[ppf_pkg::DB_SERIAL_WAKE];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_oe_q     <= 1'h0;
      wake_prev_q   <= ppf_pkg::PIN_HIGH;
      obff_event_q  <= 1'h0;
      obff_active_q <= 1'h0;
      aux_ok_q      <= 1'h0;
      rc_oe_q       <= '0;
      rc_seen_q     <= '0;
      sel_n_q       <= {ppf_pkg::SPI_HOSTS{ppf_pkg::SEL_IDLE}};
      sclk_q        <= '0;
      alert_q       <= '0;
      smb_alert_q   <= 1'h0;
      scl_high_q    <= ppf_pkg::PIN_HIGH;
      scl_cnt_q     <= '0;
      ser_oe_q      <= 1'h0;
      ser_seen_q    <= 1'h0;
    end else if (ce) begin
      wake_oe_q     <= wake_oe_d;
      wake_prev_q   <= wake_prev_d;
      obff_event_q  <= obff_event_d;
      obff_active_q <= obff_active_d;
      aux_ok_q      <= aux_ok_d;
      rc_oe_q       <= rc_oe_d;
      rc_seen_q     <= rc_seen_d;
      sel_n_q       <= sel_n_d;
      sclk_q        <= sclk_d;
      alert_q       <= alert_d;
      smb_alert_q   <= smb_alert_d;
      scl_high_q    <= scl_high_d;
      scl_cnt_q     <= scl_cnt_d;
      ser_oe_q      <= ser_oe_d;
      ser_seen_q    <= ser_seen_d;
    end
  end

  // open-drain pins only ever drive low
  assign link_wake_out_n            = ppf_pkg::PIN_LOW;
  assign link_wake_oe               = wake_oe_q;
  assign obff_event                 = obff_event_q;
  assign obff_active                = obff_active_q;
  assign aux_pulldown_en            = sel_aux_power;
  assign aux_pme_d3cold_ok          = aux_ok_q;
  assign port0_refclk_request_n_out = ppf_pkg::PIN_LOW;
  assign port0_refclk_request_n_oe  = rc_oe_q[0];
  assign port1_refclk_request_n_out = ppf_pkg::PIN_LOW;
  assign port1_refclk_request_n_oe  = rc_oe_q[1];
  assign refclk_req_seen            = rc_seen_q;
  assign spi_host0_select_n         = sel_n_q[0];
  assign spi_host1_select_n         = sel_n_q[1];
  assign spi_host0_clock_out        = sclk_q[0];
  assign spi_host1_clock_out        = sclk_q[1];
  assign spi_alert                  = alert_q;
  assign smbus_host_clock_out       = ppf_pkg::PIN_LOW;
  assign smbus_host_clock_oe        = ~scl_high_q;
  assign smbus_alert                = smb_alert_q;
  assign serial0_wake_out_n         = ppf_pkg::PIN_LOW;
  assign serial0_wake_oe            = ser_oe_q;
  assign serial0_wake_seen          = ser_seen_q;

endmodule

/* bench/ppf_checker.sv */
// port assertions for the pin function block
// assumes one clock, synchronous active-high reset; attached by bind
`timescale 1ns/1ps
module ppf_checker (
  // clock, reset, clock enable
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            ce,
  // link wake and aux detect
  input wire logic            sel_link_wake,
  input wire logic            obff_mode,
  input wire logic            wake_event,
  input wire logic            link_wake_oe,
  input wire logic            obff_event,
  input wire logic            obff_active,
  input wire logic            sel_aux_power,
  input wire logic            aux_power_detect,
  input wire logic            aux_pulldown_en,
  input wire logic            aux_pme_d3cold_ok,
  // clock request and spi host 0
  input wire logic [1:0]      sel_refclk_req,
  input wire logic [1:0]      refclk_req_assert,
  input wire logic            port0_refclk_request_n_oe,
  input wire logic [1:0]      sel_spi_host,
  input wire logic [1:0][6:0] spi_select_req,
  input wire logic [6:0]      spi_host0_select_n,
  input wire logic [3:0]      db_enable,
  input wire logic            spi_host0_alert_in_n,
  input wire logic [1:0]      spi_alert,
  // smbus clock
  input wire logic            sel_smbus_clock,
  input wire logic            smbus_clock_run,
  input wire logic            smbus_host_clock_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic       prev_oe_q;
  logic [7:0] gap_q;
  logic [7:0] run_q;
  // cycles since the last scl drive change, and length of the running stretch
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_oe_q <= 1'h0;
      gap_q     <= 8'h00;
      run_q     <= 8'h00;
    end else begin
      prev_oe_q <= smbus_host_clock_oe;
      gap_q     <= (smbus_host_clock_oe != prev_oe_q) ? 8'h00 : gap_q + 8'h01;
      run_q     <= !(ce && sel_smbus_clock && smbus_clock_run) ? 8'h00 : run_q + {7'h00, run_q != 8'hff};
    end
  end
  wake_pull_a: assert property (ce && sel_link_wake && !obff_mode |=> link_wake_oe == $past(wake_event))
    else $error("wake pin drive does not follow the wake event");
  obff_pulse_a: assert property (obff_event && $past(ce) |-> obff_active && !$past(obff_active))
    else $error("flush/fill event without a fresh low level");
  aux_pull_a: assert property (aux_pulldown_en == sel_aux_power)
    else $error("aux pull-down does not follow its select");
  aux_level_a: assert property (ce && sel_aux_power |=> aux_pme_d3cold_ok == $past(aux_power_detect))
    else $error("aux detect level misread");
  aux_force_a: assert property (ce && !sel_aux_power |=> !aux_pme_d3cold_ok)
    else $error("aux detect not forced low when unselected");
  refclk_drive_a: assert property (ce && sel_refclk_req[0] |=> port0_refclk_request_n_oe == $past(refclk_req_assert[0]))
    else $error("clock request drive wrong");
  select_drive_a: assert property (ce && sel_spi_host[0] |=> spi_host0_select_n == ~$past(spi_select_req[0]))
    else $error("chip selects not active low");
  alert_raw_a: assert property (ce && sel_spi_host[0] && !db_enable[0] |=> spi_alert[0] == !$past(spi_host0_alert_in_n))
    else $error("raw alert not passed");
  alert_unsel_a: assert property (ce && !sel_spi_host[0] |=> !spi_alert[0])
    else $error("alert active while unselected");
  smb_half_a: assert property ((smbus_host_clock_oe != prev_oe_q) && run_q > 8'h2d |-> gap_q == 8'h13)
    else $error("scl half period not 20 cycles");
  smb_stop_a: assert property (ce && !(sel_smbus_clock && smbus_clock_run) |=> !smbus_host_clock_oe)
    else $error("scl not released when stopped");
  cover property (link_wake_oe);
  cover property (obff_event);
  cover property (spi_alert[0] && !db_enable[0]);
  cover property ((smbus_host_clock_oe != prev_oe_q) && run_q > 8'h2d);
endmodule
bind ppf_pin_functions ppf_checker i_chk (.*);

/* bench/ppf_host_model.sv */
// platform side of the shared pins: pull-ups and open-drain pull-downs
// assumes oe high means the device pulls that pin low
`timescale 1ns/1ps
module ppf_host_model (
  // drive from both sides: wake, refclk0, refclk1, serial wake
  input  wire logic [3:0] dev_oe,
  input  wire logic [3:0] host_low,
  // resolved pin levels
  output      logic [3:0] pin_n,
  output      logic       spi_target_clock_in,
  output      logic       spi_target_select_n
);
  // wired-and with pull-up; platform pulls the wake pin for flush/fill events
  assign pin_n = ~(dev_oe | host_low);
  // spi target clock stays low through reset, select held high
  assign spi_target_clock_in = 1'h0;
  assign spi_target_select_n = 1'h1;
endmodule

/* bench/tb_top.sv */
// self-checking bench for the pin function block
// assumes the platform model resolves open-drain pins
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic lw, oa, ax; logic [1:0] ro, rs; logic so, c0, c1; logic [6:0] s0, s1; logic [4:0] z;}
    ppf_exp_s;
  logic clk = 1'h0, reset = 1'h1, ce, sel_link_wake, obff_mode, sel_aux_power, sel_smbus_alert, sel_smbus_clock;
  logic sel_serial0_wake, wake_event, link_wake_out_n, link_wake_oe, obff_event, obff_active, aux_power_detect;
  logic [1:0] sel_refclk_req, sel_spi_host, refclk_req_assert, spi_clock_req, spi_alert, refclk_req_seen;
  logic [3:0] db_enable, host_low;
  logic [3:0][15:0] db_time;
  logic aux_pulldown_en, aux_pme_d3cold_ok, port0_refclk_request_n_out, port0_refclk_request_n_oe;
  logic port1_refclk_request_n_out, port1_refclk_request_n_oe, spi_host0_clock_out, spi_host1_clock_out;
  logic [1:0][6:0] spi_select_req;
  logic [6:0] spi_host0_select_n, spi_host1_select_n;
  logic smbus_clock_run, smbus_host_clock_out, smbus_host_clock_oe, smbus_alert, serial0_wake_req;
  logic serial0_wake_out_n, serial0_wake_oe, serial0_wake_seen;
  logic [2:0] alert_low;
  wire link_wake_in_n, port0_refclk_request_n_in, port1_refclk_request_n_in, serial0_wake_in_n;
  wire spi_host0_alert_in_n = ~alert_low[0];
  wire spi_host1_alert_in_n = ~alert_low[1];
  wire smbus_host_alert_in_n = ~alert_low[2];
  int err_count = 0, n_checks = 0, cyc = 0;
  ppf_pin_functions #(.DB_W(16)) i_dut (.*);
  ppf_host_model i_host (
    .dev_oe              ({serial0_wake_oe, port1_refclk_request_n_oe, port0_refclk_request_n_oe, link_wake_oe}),
    .host_low            (host_low),
    .pin_n               ({serial0_wake_in_n, port1_refclk_request_n_in, port0_refclk_request_n_in, link_wake_in_n}),
    .spi_target_clock_in (),
    .spi_target_select_n ()
  );
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rnd_inputs();
    {sel_link_wake, obff_mode, sel_aux_power, sel_refclk_req, sel_spi_host, sel_smbus_alert, sel_smbus_clock,
     smbus_clock_run, sel_serial0_wake, wake_event, aux_power_detect, refclk_req_assert, spi_clock_req,
     serial0_wake_req, host_low, alert_low, spi_select_req, db_enable} = 43'({$urandom, $urandom});
    ce = ($urandom % 8) != 0;
  endtask
  task automatic do_reset();
    @(negedge clk);
    reset = 1'h1;
    repeat (4) @(negedge clk);
    reset = 1'h0;
    ce = 1'h1;
  endtask
  // next registered outputs from the inputs now and the pin drive now
  function automatic ppf_exp_s exp_next(ppf_exp_s p);
    ppf_exp_s e;
    e.lw = sel_link_wake & ~obff_mode & wake_event;
    e.oa = sel_link_wake & obff_mode & (p.lw | host_low[0]);
    e.ax = sel_aux_power & aux_power_detect;
    e.ro = sel_refclk_req & refclk_req_assert;
    e.rs = sel_refclk_req & (p.ro | host_low[2:1]);
    e.so = sel_serial0_wake & serial0_wake_req;
    e.c0 = sel_spi_host[0] & spi_clock_req[0];
    e.c1 = sel_spi_host[1] & spi_clock_req[1];
    e.s0 = sel_spi_host[0] ? ~spi_select_req[0] : 7'h7f;
    e.s1 = sel_spi_host[1] ? ~spi_select_req[1] : 7'h7f;
    e.z = 5'h00;
    return e;
  endfunction
  function automatic ppf_exp_s obs();
    return {link_wake_oe, obff_active, aux_pme_d3cold_ok, port1_refclk_request_n_oe, port0_refclk_request_n_oe,
            refclk_req_seen, serial0_wake_oe, spi_host0_clock_out, spi_host1_clock_out, spi_host0_select_n,
            spi_host1_select_n, link_wake_out_n, port0_refclk_request_n_out, port1_refclk_request_n_out,
            smbus_host_clock_out, serial0_wake_out_n};
  endfunction
  function automatic logic seen_bit(int ch);
    logic [3:0] s;
    s = {serial0_wake_seen, smbus_alert, spi_alert};
    return s[ch];
  endfunction
  task automatic set_low(int ch, logic v);
    {host_low[3], alert_low} = {3'h0, v} << ch;
  endtask
  task automatic random_run(int n);
    ppf_exp_s e;
    logic     wp;
    logic     ev;
    do_reset();
    e  = '{s0: 7'h7f, s1: 7'h7f, default: '0};
    wp = 1'h1;
    ev = 1'h0;
    for (int i = 0; i < n; i++) begin
      rnd_inputs();
      if (ce) begin
        // flush/fill event: wake pin was high at the last enabled edge and is low now
        ev = sel_link_wake & obff_mode & wp & (e.lw | host_low[0]);
        wp = ~(e.lw | host_low[0]);
        e  = exp_next(e);
      end
      @(negedge clk);
      check("pin outputs", 32'(obs()), 32'(e));
      check("flush/fill event", 32'(obff_event), 32'(ev));
      check("aux pull-down", 32'(aux_pulldown_en), 32'(sel_aux_power));
    end
    $display("test random done");
  endtask
  task automatic db_check(int ch);
    int k;
    do_reset();
    sel_spi_host = 2'h3;
    sel_smbus_alert = 1'h1;
    sel_serial0_wake = 1'h1;
    serial0_wake_req = 1'h0;
    db_enable = 4'hf;
    db_time[ch] = 16'h0008;
    set_low(ch, 1'h0);
    repeat (4) @(negedge clk);
    set_low(ch, 1'h1);
    repeat (3) @(negedge clk);
    set_low(ch, 1'h0);
    @(negedge clk);
    set_low(ch, 1'h1);
    k = 0;
    while (seen_bit(ch) !== 1'h1 && k < 30) begin
      @(negedge clk);
      k++;
    end
    check("debounce delay", 32'(k >= 9 && k <= 13), 32'h1);
    set_low(ch, 1'h0);
    db_enable[ch] = 1'h0;
    @(negedge clk);
    check("raw high", 32'(seen_bit(ch)), 32'h0);
    set_low(ch, 1'h1);
    @(negedge clk);
    check("raw low", 32'(seen_bit(ch)), 32'h1);
    $display("test debounce %0d done", ch);
  endtask
  task automatic smb_check();
    int k;
    do_reset();
    sel_smbus_clock = 1'h1;
    smbus_clock_run = 1'h1;
    k = 0;
    while (smbus_host_clock_oe !== 1'h1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (smbus_host_clock_oe === 1'h1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    while (smbus_host_clock_oe === 1'h0 && k < 90) begin
      @(negedge clk);
      k++;
    end
    check("scl period", 32'(k), 32'd40);
    smbus_clock_run = 1'h0;
    @(negedge clk);
    check("scl released", 32'(smbus_host_clock_oe), 32'h0);
    $display("test smbus clock done");
  endtask
  initial begin
    void'($urandom(32'h83be1d61));
    rnd_inputs();
    db_time = {4{16'h0003}};
    random_run(1500);
    for (int ch = 0; ch < 4; ch++)
      db_check(ch);
    smb_check();
    close_out();
  end
endmodule
